// file: design/io_bus_adc_dac_glue.sv
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module io_bus_adc_dac_glue
    import adc_dac_glue_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire io_bus_t bus_i,
    output io_bus_t bus_o,
    output logic bus_data_oe_o,
    input wire logic [DATA_W-1:0] adc_data_i,
    input wire logic adc_done_i,
    output adc_ctrl_t adc_ctrl_o,
    output logic [DATA_W-1:0] dac_latch_o,
    output logic irq_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o
);

    // **********************************************
    // strobe decode
    // **********************************************
    logic adc_sel;
    logic rd_stb;
    logic wr_stb;
    logic wr_stb_d_r;
    logic adc_rd;
    logic adc_wr;
    logic dac_wr;

    assign adc_sel = ~bus_i.addr_line_twelve;
    assign rd_stb = ~bus_i.strobe_n & bus_i.read_not_write;
    assign wr_stb = ~bus_i.strobe_n & ~bus_i.read_not_write;
    assign adc_rd = adc_sel & rd_stb;
    assign adc_wr = adc_sel & wr_stb;
    // latch clock is the falling edge of the write strobe wr_stb, i.e. strobe release
    // line twelve may drop with the strobe, so the select is taken from the delayed term
    assign dac_wr = wr_stb_d_r & ~wr_stb;

    // **********************************************
    // converter controls, registered outputs
    // **********************************************
    adc_ctrl_t ctrl_r;
    adc_ctrl_t ctrl_nxt;

    always_comb begin
        ctrl_nxt.start_conv_n = ~adc_wr;
        ctrl_nxt.output_enable_n = ~adc_rd;
        ctrl_nxt.buf_enable = adc_rd;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= '{start_conv_n: 1'b1, output_enable_n: 1'b1, buf_enable: 1'b0};
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign adc_ctrl_o = ctrl_r;

    // **********************************************
    // processor data bus return path
    // **********************************************
    io_bus_t bus_r;
    logic data_oe_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_r <= '0;
            data_oe_r <= 1'b0;
        end else begin
            bus_r <= '0;
            bus_r.strobe_n <= 1'b1;
            // data only driven back while converter read is live
            bus_r.data <= adc_rd ? adc_data_i : '0;
            data_oe_r <= adc_rd;
        end
    end

    assign bus_o = bus_r;
    assign bus_data_oe_o = data_oe_r;

    // **********************************************
    // dac latch
    // **********************************************
    logic [DATA_W-1:0] wr_data_r;
    logic [DATA_W-1:0] dac_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_stb_d_r <= 1'b0;
            wr_data_r <= DAC_RST;
        end else begin
            wr_stb_d_r <= wr_stb & bus_i.addr_line_twelve;
            // data is sampled during the strobe for hold margin
            if (wr_stb) begin
                wr_data_r <= bus_i.data;
            end
        end
    end

    logic sw_dac_wr;
    assign sw_dac_wr = reg_wr_i && reg_addr_i == OFS_DAC;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dac_r <= DAC_RST;
        end else if (dac_wr) begin
            dac_r <= wr_data_r;
        end else if (sw_dac_wr) begin
            dac_r <= reg_wdata_i[DATA_W-1:0];
        end
        // reads never touch the latch
    end

    assign dac_latch_o = dac_r;

    // **********************************************
    // end of conversion synchroniser and edge
    // **********************************************
    logic done_s1_r;
    logic done_s2_r;
    logic done_s3_r;
    logic done_pulse;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            done_s3_r <= 1'b0;
        end else begin
            done_s1_r <= adc_done_i;
            done_s2_r <= done_s1_r;
            done_s3_r <= done_s2_r;
        end
    end

    assign done_pulse = done_s2_r & ~done_s3_r;

    // **********************************************
    // cycle tracker: counts strobe length for status
    // **********************************************
    cyc_state_t state_r;
    cyc_state_t state_nxt;
    logic [7:0] cyc_len_r;
    logic [7:0] last_len_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (!bus_i.strobe_n) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (bus_i.strobe_n) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            cyc_len_r <= 8'h00;
            last_len_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_ACCESS) begin
                cyc_len_r <= cyc_len_r + 8'h01;
            end else begin
                cyc_len_r <= 8'h00;
            end
            // strobe length shows the processor's wait setting
            if (state_r == ST_ACCESS && state_nxt == ST_HOLD) begin
                last_len_r <= cyc_len_r + 8'h01;
            end
        end
    end

    // **********************************************
    // interrupt status, enable and clear
    // **********************************************
    logic [2:0] status_r;
    logic [2:0] enable_r;
    logic [2:0] events;
    logic [2:0] clr;
    logic [11:0] result_r;
    logic [15:0] conv_count_r;
    logic irq_r;
    logic adc_wr_d_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            adc_wr_d_r <= 1'b0;
        end else begin
            adc_wr_d_r <= adc_wr;
        end
    end

    assign events = {dac_wr, adc_wr & ~adc_wr_d_r, done_pulse};
    assign clr = (reg_wr_i && reg_addr_i == OFS_CLEAR) ? reg_wdata_i[2:0] : 3'h0;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_r <= 3'h0;
        end else begin
            // a new event wins over a clear in the same cycle
            status_r <= (status_r & ~clr) | events;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_r <= ENABLE_RST;
        end else if (reg_wr_i && reg_addr_i == OFS_ENABLE) begin
            enable_r <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_r <= 12'h000;
            conv_count_r <= 16'h0000;
        end else begin
            if (adc_rd) begin
                result_r <= adc_data_i;
            end
            if (done_pulse) begin
                conv_count_r <= conv_count_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(((status_r & ~clr) | events) & enable_r);
        end
    end

    assign irq_o = irq_r;

    // **********************************************
    // register read port
    // **********************************************
    logic [15:0] rdata_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_CTRL: rdata_r <= {6'h00, last_len_r, state_r};
                OFS_STATUS: rdata_r <= {13'h0000, status_r};
                OFS_ENABLE: rdata_r <= {13'h0000, enable_r};
                OFS_DAC: rdata_r <= {4'h0, dac_r};
                OFS_ADC: rdata_r <= {4'h0, result_r};
                OFS_COUNT: rdata_r <= conv_count_r;
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_r;

endmodule : io_bus_adc_dac_glue

// file: design/adc_dac_glue_pkg.sv
package adc_dac_glue_pkg;

    // **********************************************
    // address map of the expansion i/o space
    // **********************************************
    localparam int ADDR_W = 13;
    localparam int DATA_W = 12;
    localparam int ADC_IO_ADDR = 32'h0080_4000;
    localparam int DAC_IO_ADDR = 32'h0080_5000;
    localparam int SEL_BIT = 12;

    // **********************************************
    // register interface offsets
    // **********************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_CLEAR = 4'h2;
    localparam logic [3:0] OFS_ENABLE = 4'h3;
    localparam logic [3:0] OFS_DAC = 4'h4;
    localparam logic [3:0] OFS_ADC = 4'h5;
    localparam logic [3:0] OFS_COUNT = 4'h6;

    // interrupt status bit positions
    localparam int ST_DONE = 0;
    localparam int ST_START = 1;
    localparam int ST_DACWR = 2;

    localparam logic [2:0] ENABLE_RST = 3'h0;
    localparam logic [DATA_W-1:0] DAC_RST = 12'h000;
    localparam logic [1:0] WAIT_RD = 2'h2;

    // **********************************************
    // grouped signals
    // **********************************************
    typedef struct packed {
        logic strobe_n;
        logic read_not_write;
        logic addr_line_twelve;
        logic [DATA_W-1:0] data;
    } io_bus_t;

    typedef struct packed {
        logic start_conv_n;
        logic output_enable_n;
        logic buf_enable;
    } adc_ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01,
        ST_HOLD = 2'b10
    } cyc_state_t;

endpackage : adc_dac_glue_pkg

// file: tb/adc_model.sv
`timescale 1ns/10ps
module adc_model
    import adc_dac_glue_pkg::*;
#(
    parameter int CONV_CYC = 50
)
(
    input wire adc_ctrl_t ctrl_i,
    input wire logic clk_i,
    output logic [DATA_W-1:0] data_o,
    output logic done_o
);
    int cnt_r = 0;
    logic [DATA_W-1:0] res_r = 12'h5A0;
    logic start_r = 1'h1;
    initial done_o = 1'h0;
    // ****************************************
    // one conversion per start, no free run
    // ****************************************
    always @(posedge clk_i) begin
        start_r <= ctrl_i.start_conv_n;
        if (start_r && !ctrl_i.start_conv_n) begin
            cnt_r <= CONV_CYC;
            done_o <= 1'h0;
        end else if (cnt_r == 1) begin
            cnt_r <= 0;
            res_r <= res_r + 12'h001;
            done_o <= 1'h1;
        end else if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1;
        end
    end
    // released outputs show junk, so stale data cannot pass for good
    assign data_o = ctrl_i.output_enable_n ? ~res_r : res_r;
endmodule : adc_model

// file: tb/glue_chk_sva.sv
`timescale 1ns/10ps
module glue_chk
    import adc_dac_glue_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire io_bus_t bus_i,
    input wire io_bus_t bus_o,
    input wire logic bus_data_oe_o,
    input wire logic [DATA_W-1:0] adc_data_i,
    input wire logic adc_done_i,
    input wire adc_ctrl_t adc_ctrl_o,
    input wire logic [DATA_W-1:0] dac_latch_o,
    input wire logic irq_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o
);
    logic wr_cv, rd_cv, dac_wr, dac_up, reg_dac, dac_wr_r;
    logic [2:0] en_r;
    assign wr_cv = !bus_i.strobe_n && !bus_i.read_not_write && !bus_i.addr_line_twelve;
    assign rd_cv = !bus_i.strobe_n && bus_i.read_not_write && !bus_i.addr_line_twelve;
    assign dac_wr = !bus_i.strobe_n && !bus_i.read_not_write && bus_i.addr_line_twelve;
    assign dac_up = dac_wr_r && bus_i.strobe_n;
    assign reg_dac = reg_wr_i && reg_addr_i == OFS_DAC;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dac_wr_r <= 1'h0;
            en_r <= 3'h0;
        end else begin
            dac_wr_r <= dac_wr;
            if (reg_wr_i && reg_addr_i == OFS_ENABLE) begin
                en_r <= reg_wdata_i[2:0];
            end
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence dac_wr_s;
        dac_wr ##1 bus_i.strobe_n;
    endsequence
    start_pulse_a: assert property (adc_ctrl_o.start_conv_n == !$past(wr_cv))
        else $error("start control wrong");
    read_enable_a: assert property (adc_ctrl_o.output_enable_n == !$past(rd_cv))
        else $error("output enable wrong");
    buf_drive_a: assert property (bus_data_oe_o == $past(rd_cv))
        else $error("bus drive wrong");
    read_data_a: assert property (bus_data_oe_o |-> bus_o.data == $past(adc_data_i))
        else $error("read data wrong");
    idle_data_a: assert property (!bus_data_oe_o |-> bus_o.data == 12'h000)
        else $error("data leaks");
    latch_load_a: assert property (dac_wr_s |=> dac_latch_o == $past(bus_i.data, 2))
        else $error("latch not loaded");
    latch_hold_a:
        assert property ($changed(dac_latch_o) |-> $past(dac_up) || $past(reg_dac)
            || $past(reg_dac, 2)) else $error("latch moved");
    done_irq_a: assert property ($rose(adc_done_i) && en_r[0] |-> ##[1:4] irq_o)
        else $error("no interrupt");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data stray");
endmodule : glue_chk
bind io_bus_adc_dac_glue glue_chk glue_chk_inst (.*);

// file: tb/io_bus_adc_dac_glue_bench.sv
`timescale 1ns/10ps
module io_bus_adc_dac_glue_bench import adc_dac_glue_pkg::*;;
    logic clk_i = 1'h0;
    logic resetn_i = 1'h0;
    io_bus_t bus_r = '{1'h1, 1'h0, 1'h0, 12'h000};
    io_bus_t bus_o;
    adc_ctrl_t ctrl;
    logic oe, irq, done, wr_r, rd_r, seen;
    logic [DATA_W-1:0] adc, latch, rd;
    logic [3:0] ra_r = 4'h0;
    logic [15:0] wd_r = 16'h0000;
    logic [15:0] rdata;
    int fails = 0;
    int compares = 0;
    initial forever #50 clk_i = ~clk_i;
    io_bus_adc_dac_glue io_bus_adc_dac_glue_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .bus_i(bus_r), .bus_o(bus_o), .bus_data_oe_o(oe), .adc_data_i(adc), .adc_done_i(done),
        .adc_ctrl_o(ctrl), .dac_latch_o(latch), .irq_o(irq), .reg_addr_i(ra_r),
        .reg_wdata_i(wd_r), .reg_wr_i(wr_r), .reg_rd_i(rd_r), .reg_rdata_o(rdata));
    adc_model adc_model_inst (.clk_i(clk_i), .ctrl_i(ctrl), .data_o(adc), .done_o(done));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // reads hold two extra strobe cycles; released data lines show junk
    task automatic io_cyc(input logic rnw, input logic a12, input logic [DATA_W-1:0] d);
        int n;
        n = rnw ? 3 : 1;
        seen = 1'h0;
        bus_r <= '{1'h0, rnw, a12, rnw ? ~bus_r.data : d};
        for (int i = 1; i <= n; i++) begin
            @(posedge clk_i);
            if (i == n) bus_r.strobe_n <= 1'h1;
            #1;
            seen = seen | oe;
            rd = bus_o.data;
        end
        @(posedge clk_i);
        #1;
    endtask : io_cyc
    task automatic reg_acc(input logic w, input logic [3:0] a, input logic [15:0] v);
        ra_r <= a;
        wd_r <= v;
        wr_r <= w;
        rd_r <= !w;
        @(posedge clk_i);
        wr_r <= 1'h0;
        rd_r <= 1'h0;
        #1;
        if (!w) chk(rdata, v);
        @(posedge clk_i);
        #1;
    endtask : reg_acc
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'h1 && k < 300) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk(16'(irq), 16'h0001);
        if (k == 300) close_out();
    endtask : wait_irq
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        wr_r = 1'h0;
        rd_r = 1'h0;
        repeat (12) @(posedge clk_i);
        chk(16'(ctrl), 16'h0006);
        chk(16'(latch), 16'h0000);
        resetn_i <= 1'h1;
        @(posedge clk_i);
        reg_acc(1'h0, OFS_ENABLE, 16'(ENABLE_RST));
        reg_acc(1'h1, OFS_ENABLE, 16'h0001);
        io_cyc(1'h0, 1'h0, 12'hABC);
        chk(16'(seen), 16'h0000);
        wait_irq();
        reg_acc(1'h1, OFS_ENABLE, 16'h0000);
        chk(16'(irq), 16'h0000);
        reg_acc(1'h0, OFS_STATUS, 16'h0003);
        io_cyc(1'h1, 1'h0, 12'h000);
        chk(16'(seen), 16'h0001);
        chk(16'(rd), 16'h05A1);
        io_cyc(1'h0, 1'h1, 12'h3C5);
        @(posedge clk_i);
        #1;
        chk(16'(latch), 16'h03C5);
        reg_acc(1'h0, OFS_STATUS, 16'h0007);
        io_cyc(1'h1, 1'h1, 12'h000);
        chk(16'(seen), 16'h0000);
        chk(16'(latch), 16'h03C5);
        reg_acc(1'h0, OFS_DAC, 16'h03C5);
        reg_acc(1'h1, OFS_ENABLE, 16'h0001);
        wait_irq();
        reg_acc(1'h1, OFS_CLEAR, 16'h0007);
        reg_acc(1'h0, OFS_STATUS, 16'h0000);
        chk(16'(irq), 16'h0000);
        reg_acc(1'h0, 4'hF, 16'h0000);
        close_out();
    end
endmodule : io_bus_adc_dac_glue_bench
